/* File: cgc_pkg.sv */
package cgc_pkg;

    // ========================================================================
    // Register offsets within the group window.
    // ========================================================================
    localparam logic [11:0] OFF_GROUP_BASE   = 12'h000;
    localparam logic [11:0] OFF_DUAL_BASE    = 12'h004;
    localparam logic [11:0] OFF_SERVICE_REQ  = 12'h008;
    localparam logic [11:0] OFF_INT_STATUS   = 12'h00C;
    localparam logic [11:0] OFF_TX_SLOT_MAP  = 12'h200;
    localparam logic [11:0] OFF_TX_SUB_MAP   = 12'h280;
    localparam logic [11:0] OFF_TX_CHAN_CFG  = 12'h380;
    localparam logic [11:0] OFF_RX_SLOT_MAP  = 12'h400;
    localparam logic [11:0] OFF_RX_SUB_MAP   = 12'h480;
    localparam logic [11:0] OFF_RX_CHAN_CFG  = 12'h580;
    localparam logic [11:0] OFF_DEVICE_WIDE  = 12'h600;
    localparam logic [11:0] OFF_EVQ_POINTER  = 12'h604;
    localparam logic [11:0] OFF_EVQ_LENGTH   = 12'h608;
    localparam logic [11:0] OFF_GROUP_CFG    = 12'h60C;
    localparam logic [11:0] OFF_MEM_GUARD    = 12'h610;
    localparam logic [11:0] OFF_FRAME_LIMITS = 12'h614;
    localparam logic [11:0] OFF_SERIAL_PORT  = 12'h618;

    // ========================================================================
    // Service request commands: fetch one descriptor dword from shared memory, two for the event queue.
    // ========================================================================
    localparam logic [3:0] SRQ_FETCH_DEVICE_WIDE = 4'h1;
    localparam logic [3:0] SRQ_FETCH_EVQ         = 4'h2;
    localparam logic [3:0] SRQ_FETCH_GROUP_CFG   = 4'h3;
    localparam logic [3:0] SRQ_FETCH_MEM_GUARD   = 4'h4;
    localparam logic [3:0] SRQ_FETCH_LIMITS      = 4'h5;
    localparam logic [3:0] SRQ_FETCH_SERIAL_PORT = 4'h6;
    localparam logic [3:0] SRQ_FIELD_LSB         = 4'h0;

    // ========================================================================
    // Field layouts and constants.
    // ========================================================================
    localparam int          GRP_BASE_ALIGN_BITS = 11;
    localparam logic [31:0] ALL_ONES            = 32'hFFFF_FFFF;
    localparam logic [31:0] RESET_ZERO          = 32'h0000_0000;
    localparam logic [31:0] DEVW_RO_MASK        = 32'h0000_00FF;
    localparam logic [31:0] EVQ_PTR_MASK        = 32'hFFFF_FFFC;
    localparam logic [31:0] EVQ_LEN_MASK        = 32'h0000_7FFF;
    localparam int          DEVW_EXP_CLK_ON     = 8;
    localparam int          DEVW_CPU_PROTO      = 9;
    localparam int          DEVW_PMAP_LSB       = 10;
    localparam int          GCF_RXEN            = 0;
    localparam int          GCF_TXEN            = 1;
    localparam int          GCF_SUBDIS          = 2;
    localparam int          GCF_LOSS_ABORT      = 3;
    localparam int          GCF_LOSS_MASK       = 4;
    localparam int          GCF_ALIGN_MASK      = 5;
    localparam int          GCF_MCEN            = 6;
    localparam int          GCF_FAULT_ACT       = 7;
    localparam int          GCF_INHR            = 8;
    localparam int          GCF_INHT            = 9;
    localparam int          GCF_POLL_LSB        = 10;
    localparam int          GCF_SF_SOURCE       = 12;

    typedef enum {
        ST_IDLE,
        ST_FETCH,
        ST_WAIT
    } cgc_state_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cgc_slave_req_type;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } cgc_fetch_req_type;
endpackage

/* File: cgc_regs.sv */
`timescale 1ns/1ns
// Summary of operation
// RL1 - Host aligns each group structure on a 2 kB boundary before use.
// RL2 - Group base pointer changes only by direct slave write, never by request.
// RL3 - Requests fetch descriptors at fixed byte offsets from the group base.
// RL4 - Map and configuration descriptors sit at fixed offsets 0x200 to 0x618.
// RL5 - Line clock seen bits are read only; writes to them are discarded.
// RL6 - Expansion clock output stays off while its enable bit is zero.
// RL7 - Protocol select zero picks the first local bus handshake style.
// RL8 - Routing field zero sends serial port n to group n.
// RL9 - Host gives the event queue pointer on a four byte boundary.
// RL10 - Event queue size field is a zero based entry count.
// RL11 - Host sizes the event queue between 2 and 32768 dword entries.
// RL12 - Queue pointer at 0x604 and length at 0x608, written separately.
// RL13 - Each descriptor loads by slave write or by a fetch request; here descriptors below 0x600 load by neither.
// RL14 - Poll interval one polls buffer ownership every sixteenth frame.
// RL15 - Alignment source zero keeps alignment by the internal flywheel.
// RL16 - Suppress bits zero let buffer status writes go out per direction.
// RL17 - Fault action zero resets the group on a protection violation.
// RL18 - Copy bit one copies message configuration bits during processing.
// RL19 - Mask bits zero report alignment change and frame loss events.
// RL20 - Frame loss abort zero keeps processing messages after frame loss.
// RL21 - Subchannel disable zero allows bit level subchannel mapping.
// RL22 - Transmit and receive enable bits one enable each direction.
// RL23 - Reserved or write only reads return all ones; such writes ignored.
// RL24 - With channels active host touches only base, request, status locations.
// RL25 - All registers are 32 bit dwords with zero reset values.
module cgc_regs #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_rstn,
    input  wire cgc_pkg::cgc_slave_req_type i_slave,
    output logic [31:0]                    o_rdata,
    output logic                           o_rvalid,
    output cgc_pkg::cgc_fetch_req_type     o_fetch,
    input  wire logic                      i_fetch_valid,
    input  wire logic [31:0]               i_fetch_data,
    input  wire logic [NUM_PORTS-1:0]      i_tx_clock_seen,
    input  wire logic [NUM_PORTS-1:0]      i_rx_clock_seen,
    input  wire logic [31:0]               i_int_status,
    output logic                           o_service_busy,
    output logic                           o_expansion_clock_output_on,
    output logic                           o_local_cpu_protocol_select,
    output logic [1:0]                     o_port_to_group_routing,
    output logic [31:0]                    o_event_queue_start_pointer,
    output logic [14:0]                    o_event_queue_size_minus_one,
    output logic [15:0]                    o_event_queue_entries,
    output logic [1:0]                     o_ownership_poll_interval,
    output logic                           o_superframe_align_source,
    output logic                           o_suppress_tx_buffer_status_write,
    output logic                           o_suppress_rx_buffer_status_write,
    output logic                           o_protection_fault_action,
    output logic                           o_message_config_copy_on,
    output logic                           o_alignment_change_irq_mask,
    output logic                           o_frame_loss_irq_mask,
    output logic                           o_frame_loss_abort,
    output logic                           o_subchannel_disable,
    output logic                           o_transmit_enable,
    output logic                           o_receive_enable
);

    // ========================================================================
    // State record.
    // ========================================================================
    typedef struct packed {
        cgc_pkg::cgc_state_type state;
        logic [31:0]            group_struct_base;
        logic [31:0]            dual_cycle_base;
        logic [31:0]            service_request;
        logic [31:0]            device_wide_settings;
        logic [31:0]            event_queue_pointer;
        logic [31:0]            event_queue_length;
        logic [31:0]            group_settings;
        logic [31:0]            memory_guard;
        logic [31:0]            frame_length_limits;
        logic [31:0]            serial_port_settings;
        logic [11:0]            fetch_off;
        logic [31:0]            fetch_addr;
        logic                   fetch_req;
        logic                   busy;
        logic [31:0]            rdata;
        logic                   rvalid;
        logic [15:0]            evq_entries;
    } cgc_regs_state_type;

    cgc_regs_state_type state_reg;
    cgc_regs_state_type state_next;
    logic [31:0]        clock_seen_bits;

    // ========================================================================
    // Live clock detect bits occupy the read-only low byte.
    // ========================================================================
    always_comb begin
        clock_seen_bits = '0;
        clock_seen_bits[NUM_PORTS-1:0] = i_tx_clock_seen;
        clock_seen_bits[NUM_PORTS+3:4] = i_rx_clock_seen;
    end

    // ========================================================================
    // Next state: slave access, request decode and descriptor fetch.
    // ========================================================================
    always_comb begin
        logic [11:0] a;
        logic [31:0] d;
        a = i_slave.addr;
        d = i_slave.wdata;
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        if (i_slave.valid && i_slave.write) begin
            case (a)
                cgc_pkg::OFF_GROUP_BASE: begin
                    state_next.group_struct_base = d; // RL2
                end
                cgc_pkg::OFF_DUAL_BASE: begin
                    state_next.dual_cycle_base = d;
                end
                cgc_pkg::OFF_SERVICE_REQ: begin
                    state_next.service_request = d;
                end
                cgc_pkg::OFF_DEVICE_WIDE: begin
                    state_next.device_wide_settings =
                        d & ~cgc_pkg::DEVW_RO_MASK; // RL5 RL13
                end
                cgc_pkg::OFF_EVQ_POINTER: begin
                    state_next.event_queue_pointer = d; // RL12
                end
                cgc_pkg::OFF_EVQ_LENGTH: begin
                    state_next.event_queue_length =
                        d & cgc_pkg::EVQ_LEN_MASK; // RL12
                end
                cgc_pkg::OFF_GROUP_CFG: begin
                    state_next.group_settings = d; // RL13
                end
                cgc_pkg::OFF_MEM_GUARD: begin
                    state_next.memory_guard = d;
                end
                cgc_pkg::OFF_FRAME_LIMITS: begin
                    state_next.frame_length_limits = d;
                end
                cgc_pkg::OFF_SERIAL_PORT: begin
                    state_next.serial_port_settings = d;
                end
                default: begin
                end
            endcase
        end
        if (i_slave.valid && !i_slave.write) begin
            state_next.rvalid = 1'b1;
            case (a)
                cgc_pkg::OFF_GROUP_BASE: begin
                    state_next.rdata = state_reg.group_struct_base;
                end
                cgc_pkg::OFF_DUAL_BASE: begin
                    state_next.rdata = state_reg.dual_cycle_base;
                end
                cgc_pkg::OFF_SERVICE_REQ: begin
                    state_next.rdata = state_reg.service_request;
                end
                cgc_pkg::OFF_INT_STATUS: begin
                    state_next.rdata = i_int_status;
                end
                cgc_pkg::OFF_DEVICE_WIDE: begin
                    state_next.rdata = state_reg.device_wide_settings |
                                       clock_seen_bits; // RL5
                end
                cgc_pkg::OFF_EVQ_POINTER: begin
                    state_next.rdata = state_reg.event_queue_pointer;
                end
                cgc_pkg::OFF_EVQ_LENGTH: begin
                    state_next.rdata = state_reg.event_queue_length;
                end
                cgc_pkg::OFF_GROUP_CFG: begin
                    state_next.rdata = state_reg.group_settings;
                end
                cgc_pkg::OFF_MEM_GUARD: begin
                    state_next.rdata = state_reg.memory_guard;
                end
                cgc_pkg::OFF_FRAME_LIMITS: begin
                    state_next.rdata = state_reg.frame_length_limits;
                end
                cgc_pkg::OFF_SERIAL_PORT: begin
                    state_next.rdata = state_reg.serial_port_settings;
                end
                default: begin
                    state_next.rdata = cgc_pkg::ALL_ONES; // RL23
                end
            endcase
        end
        case (state_reg.state)
            cgc_pkg::ST_IDLE: begin
                if (i_slave.valid && i_slave.write &&
                    a == cgc_pkg::OFF_SERVICE_REQ) begin
                    state_next.state = cgc_pkg::ST_FETCH;
                    state_next.busy  = 1'b1;
                    case (d[cgc_pkg::SRQ_FIELD_LSB +: 4])
                        cgc_pkg::SRQ_FETCH_DEVICE_WIDE:
                            state_next.fetch_off = cgc_pkg::OFF_DEVICE_WIDE;
                        cgc_pkg::SRQ_FETCH_EVQ:
                            state_next.fetch_off = cgc_pkg::OFF_EVQ_POINTER;
                        cgc_pkg::SRQ_FETCH_GROUP_CFG:
                            state_next.fetch_off = cgc_pkg::OFF_GROUP_CFG;
                        cgc_pkg::SRQ_FETCH_MEM_GUARD:
                            state_next.fetch_off = cgc_pkg::OFF_MEM_GUARD;
                        cgc_pkg::SRQ_FETCH_LIMITS:
                            state_next.fetch_off = cgc_pkg::OFF_FRAME_LIMITS;
                        cgc_pkg::SRQ_FETCH_SERIAL_PORT:
                            state_next.fetch_off = cgc_pkg::OFF_SERIAL_PORT;
                        default: begin
                            state_next.state = cgc_pkg::ST_IDLE;
                            state_next.busy  = 1'b0;
                        end
                    endcase
                end
            end
            cgc_pkg::ST_FETCH: begin
                state_next.fetch_addr = {state_reg.group_struct_base[31:11],
                                         11'h000} +
                                        {20'h0_0000,
                                         state_reg.fetch_off}; // RL3 RL4
                state_next.fetch_req = 1'b1;
                state_next.state     = cgc_pkg::ST_WAIT;
            end
            cgc_pkg::ST_WAIT: begin
                if (i_fetch_valid) begin
                    state_next.fetch_req = 1'b0;
                    state_next.busy      = 1'b0;
                    state_next.state     = cgc_pkg::ST_IDLE;
                    case (state_reg.fetch_off)
                        cgc_pkg::OFF_DEVICE_WIDE:
                            state_next.device_wide_settings =
                                i_fetch_data &
                                ~cgc_pkg::DEVW_RO_MASK; // RL5
                        cgc_pkg::OFF_EVQ_POINTER: begin
                            state_next.event_queue_pointer = i_fetch_data;
                            state_next.fetch_off = cgc_pkg::OFF_EVQ_LENGTH;
                            state_next.busy      = 1'b1;
                            state_next.state     = cgc_pkg::ST_FETCH;
                        end
                        cgc_pkg::OFF_EVQ_LENGTH:
                            state_next.event_queue_length =
                                i_fetch_data & cgc_pkg::EVQ_LEN_MASK;
                        cgc_pkg::OFF_GROUP_CFG:
                            state_next.group_settings = i_fetch_data; // RL13
                        cgc_pkg::OFF_MEM_GUARD:
                            state_next.memory_guard = i_fetch_data;
                        cgc_pkg::OFF_FRAME_LIMITS:
                            state_next.frame_length_limits = i_fetch_data;
                        default:
                            state_next.serial_port_settings = i_fetch_data;
                    endcase
                end
            end
            default: begin
                state_next.state = cgc_pkg::ST_IDLE;
            end
        endcase
        state_next.evq_entries =
            {1'b0, state_next.event_queue_length[14:0]} + 16'h0001; // RL10
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= '0; // RL25
            state_reg.evq_entries <= 16'h0001; // RL10
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================================================
    // Outputs, all taken straight from the state record.
    // ========================================================================
    assign o_rdata        = state_reg.rdata;
    assign o_rvalid       = state_reg.rvalid;
    assign o_fetch.req    = state_reg.fetch_req;
    assign o_fetch.addr   = state_reg.fetch_addr;
    assign o_service_busy = state_reg.busy;
    assign o_expansion_clock_output_on =
        state_reg.device_wide_settings[cgc_pkg::DEVW_EXP_CLK_ON]; // RL6
    assign o_local_cpu_protocol_select =
        state_reg.device_wide_settings[cgc_pkg::DEVW_CPU_PROTO]; // RL7
    assign o_port_to_group_routing =
        state_reg.device_wide_settings[cgc_pkg::DEVW_PMAP_LSB +: 2]; // RL8
    assign o_event_queue_start_pointer = state_reg.event_queue_pointer;
    assign o_event_queue_size_minus_one =
        state_reg.event_queue_length[14:0]; // RL10
    assign o_event_queue_entries = state_reg.evq_entries; // RL10
    assign o_ownership_poll_interval =
        state_reg.group_settings[cgc_pkg::GCF_POLL_LSB +: 2]; // RL14
    assign o_superframe_align_source =
        state_reg.group_settings[cgc_pkg::GCF_SF_SOURCE]; // RL15
    assign o_suppress_tx_buffer_status_write =
        state_reg.group_settings[cgc_pkg::GCF_INHT]; // RL16
    assign o_suppress_rx_buffer_status_write =
        state_reg.group_settings[cgc_pkg::GCF_INHR]; // RL16
    assign o_protection_fault_action =
        state_reg.group_settings[cgc_pkg::GCF_FAULT_ACT]; // RL17
    assign o_message_config_copy_on =
        state_reg.group_settings[cgc_pkg::GCF_MCEN]; // RL18
    assign o_alignment_change_irq_mask =
        state_reg.group_settings[cgc_pkg::GCF_ALIGN_MASK]; // RL19
    assign o_frame_loss_irq_mask =
        state_reg.group_settings[cgc_pkg::GCF_LOSS_MASK]; // RL19
    assign o_frame_loss_abort =
        state_reg.group_settings[cgc_pkg::GCF_LOSS_ABORT]; // RL20
    assign o_subchannel_disable =
        state_reg.group_settings[cgc_pkg::GCF_SUBDIS]; // RL21
    assign o_transmit_enable =
        state_reg.group_settings[cgc_pkg::GCF_TXEN]; // RL22
    assign o_receive_enable =
        state_reg.group_settings[cgc_pkg::GCF_RXEN]; // RL22

    // ========================================================================
    // Checks.
    // ========================================================================
    AST_BASE_ONLY_BY_WRITE: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        !(i_slave.valid && i_slave.write &&
          i_slave.addr == cgc_pkg::OFF_GROUP_BASE)
        |=> $stable(state_reg.group_struct_base)) // RL2
        else $error("group base changed without a slave write");
    AST_FETCH_OFFSET: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        $rose(o_fetch.req) |-> o_fetch.addr[10:0] ==
            state_reg.fetch_off[10:0]) // RL3
        else $error("fetch address not at fixed offset");
    AST_CLOCK_SEEN_RO: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        (state_reg.device_wide_settings & cgc_pkg::DEVW_RO_MASK) == 0) // RL5
        else $error("read only clock bits were stored");
    AST_UNMAPPED_ONES: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        (i_slave.valid && !i_slave.write &&
         i_slave.addr == cgc_pkg::OFF_TX_SLOT_MAP + 12'h004)
        |=> o_rvalid && o_rdata == cgc_pkg::ALL_ONES) // RL23
        else $error("unmapped read did not return all ones");
    AST_EVQ_LEN_WRITE: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        (i_slave.valid && i_slave.write &&
         i_slave.addr == cgc_pkg::OFF_EVQ_LENGTH && !o_service_busy)
        |=> o_event_queue_size_minus_one == $past(i_slave.wdata[14:0])) // RL12
        else $error("queue length write lost");
    AST_ENTRIES_PLUS_ONE: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        o_event_queue_entries ==
            {1'b0, o_event_queue_size_minus_one} + 16'h0001) // RL10
        else $error("entry count is not length plus one");
    AST_GROUP_CFG_WRITE: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        (i_slave.valid && i_slave.write && !o_service_busy &&
         i_slave.addr == cgc_pkg::OFF_GROUP_CFG)
        |=> o_transmit_enable == $past(i_slave.wdata[1]) &&
            o_receive_enable == $past(i_slave.wdata[0])) // RL22
        else $error("enable bits did not follow write");
    AST_REQ_FETCHES: assert property (@(posedge i_clock)
        disable iff (!i_rstn)
        (state_reg.state == cgc_pkg::ST_IDLE && i_slave.valid &&
         i_slave.write && i_slave.addr == cgc_pkg::OFF_SERVICE_REQ &&
         i_slave.wdata[3:0] == cgc_pkg::SRQ_FETCH_GROUP_CFG)
        |=> ##1 o_fetch.req) // RL13
        else $error("service request did not start a fetch");
endmodule

/* File: cgc_mem_model.sv */
`timescale 1ns/1ns
// ============================================================
// Shared memory that answers descriptor fetches, fast or slow.
module cgc_mem_model (
    input  wire logic                      i_clock,
    input  wire logic                      i_slow,
    input  wire cgc_pkg::cgc_fetch_req_type i_fetch,
    output logic                           o_valid,
    output logic [31:0]                    o_data
);
    int cnt;
    initial begin
        o_valid = 1'b0;
        o_data  = 32'h0000_0000;
        cnt     = 0;
    end
    // The data lines toggle every cycle outside the answer word.
    always @(posedge i_clock) begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
        if (i_fetch.req && !o_valid) begin
            if (cnt >= (i_slow ? 5 : 0)) begin
                o_valid <= 1'b1;
                o_data  <= i_fetch.addr + 32'h0000_0100;
                cnt     <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
// ============================================================
// Register bank test bench.
module testbench;
    logic i_clock, i_rstn, rv, busy, slow, fv, eck, txe, rxe, mcc;
    logic [1:0] rt, pol;
    logic [15:0] ent;
    logic [31:0] rd_data, fd, qp;
    logic mps, sfa, stx, srx, pfa, acm, flm, fla, sbd;
    logic [14:0] qsz;
    logic [10:0] gv;
    assign gv = {sfa, stx, srx, pfa, acm, flm, fla, sbd, mcc, txe, rxe};
    cgc_pkg::cgc_slave_req_type slv;
    cgc_pkg::cgc_fetch_req_type fr;
    int n_fail, compares, i;
    cgc_regs cgc_regs_inst (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_slave(slv), .o_rdata(rd_data), .o_rvalid(rv), .o_fetch(fr),
        .i_fetch_valid(fv), .i_fetch_data(fd), .i_tx_clock_seen(4'hA),
        .i_rx_clock_seen(4'h5), .i_int_status(32'h0000_C0DE),
        .o_service_busy(busy), .o_expansion_clock_output_on(eck),
        .o_local_cpu_protocol_select(mps), .o_port_to_group_routing(rt),
        .o_event_queue_start_pointer(qp), .o_event_queue_size_minus_one(qsz),
        .o_event_queue_entries(ent), .o_ownership_poll_interval(pol),
        .o_superframe_align_source(sfa), .o_protection_fault_action(pfa),
        .o_suppress_tx_buffer_status_write(stx), .o_frame_loss_abort(fla),
        .o_suppress_rx_buffer_status_write(srx), .o_subchannel_disable(sbd),
        .o_message_config_copy_on(mcc), .o_alignment_change_irq_mask(acm),
        .o_frame_loss_irq_mask(flm), .o_transmit_enable(txe),
        .o_receive_enable(rxe));
    cgc_mem_model cgc_mem_model_inst (.i_clock(i_clock), .i_slow(slow),
        .i_fetch(fr), .o_valid(fv), .o_data(fd));
    // ============================================================
    // Tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge i_clock) slv = '{1'b1, 1'b1, a, d};
        @(negedge i_clock) slv.valid = 1'b0;
        @(negedge i_clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge i_clock) slv = '{1'b1, 1'b0, a, 32'h0000_0000};
        @(negedge i_clock) slv.valid = 1'b0;
        chk({31'h0, rv}, 32'h0000_0001);
        chk(rd_data, exp);
    endtask
    task automatic srq(input logic [3:0] code);
        wr(cgc_pkg::OFF_SERVICE_REQ, {28'h0, code});
        for (i = 0; i < 30 && busy !== 1'b0; i++) @(negedge i_clock);
        chk({31'h0, busy}, 32'h0000_0000);
    endtask
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ============================================================
    // Clock, watchdog and test sequence.
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        #100000 n_fail++;
        test_done;
    end
    initial begin
        n_fail = 0;
        compares = 0;
        slow = 1'b0;
        i_rstn = 1'b0;
        slv = '{1'b0, 1'b0, 12'h000, 32'h0000_0000};
        repeat (12) @(posedge i_clock);
        @(negedge i_clock) i_rstn = 1'b1;
        rd(cgc_pkg::OFF_GROUP_CFG, 32'h0000_0000);
        wr(cgc_pkg::OFF_GROUP_BASE, 32'h0010_0800);
        rd(cgc_pkg::OFF_GROUP_BASE, 32'h0010_0800);
        wr(cgc_pkg::OFF_DEVICE_WIDE, 32'hFFFF_FFFF);
        rd(cgc_pkg::OFF_DEVICE_WIDE, 32'hFFFF_FF5A);
        chk({mps, eck, rt}, 32'h0000_000F);
        wr(cgc_pkg::OFF_DEVICE_WIDE, 32'h0000_0000);
        chk({mps, eck, rt}, 32'h0000_0000);
        wr(cgc_pkg::OFF_EVQ_POINTER, 32'h0002_0004);
        wr(cgc_pkg::OFF_EVQ_LENGTH, 32'h0000_0009);
        chk(ent, 32'h0000_000A);
        chk(qp, 32'h0002_0004);
        chk({17'h0_0000, qsz}, 32'h0000_0009);
        wr(cgc_pkg::OFF_GROUP_CFG, 32'h0000_10B0);
        chk({21'h00_0000, gv}, 32'h0000_04E0);
        rd(cgc_pkg::OFF_EVQ_POINTER, 32'h0002_0004);
        wr(cgc_pkg::OFF_GROUP_CFG, 32'h0000_0443);
        chk({pol, mcc, txe, rxe}, 32'h0000_000F);
        chk({21'h00_0000, gv}, 32'h0000_0007);
        rd(12'h7FC, cgc_pkg::ALL_ONES);
        wr(12'h204, 32'h0000_1234);
        rd(12'h204, cgc_pkg::ALL_ONES);
        rd(cgc_pkg::OFF_INT_STATUS, 32'h0000_C0DE);
        srq(cgc_pkg::SRQ_FETCH_GROUP_CFG);
        rd(cgc_pkg::OFF_GROUP_CFG, 32'h0010_0F0C);
        chk({21'h00_0000, gv}, 32'h0000_0318);
        slow = 1'b1;
        srq(cgc_pkg::SRQ_FETCH_EVQ);
        rd(cgc_pkg::OFF_EVQ_POINTER, 32'h0010_0F04);
        rd(cgc_pkg::OFF_EVQ_LENGTH, 32'h0000_0F08);
        chk(ent, 32'h0000_0F09);
        rd(cgc_pkg::OFF_GROUP_BASE, 32'h0010_0800);
        test_done;
    end
endmodule
